// File: oximetry_device_model.sv
// Behavioural I2C register device
`timescale 1ns/1ps
`default_nettype none
module oximetry_device_model #(parameter logic [6:0] DEV_ADDR = 7'h2a) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic scl,
	input  wire logic sda,
	output var  logic scl_pull,
	output var  logic sda_pull
);
	logic [15:0] mem [0:127];
	logic [5:0]  n_wr;
	logic [7:0]  sh, ptr, hi;
	logic [3:0]  bc;
	logic [2:0]  nb;
	logic [4:0]  hold;
	logic        ps, pd;
	always @(posedge sys_clk) begin
		ps <= scl;
		pd <= sda;
		scl_pull <= hold != 0;
		if (hold != 0)
			hold <= hold - 5'h1;
		if (rst) begin
			for (int i = 0; i < 128; i++)
				mem[i] <= 16'h0;
			mem[8'h11] <= 16'h1000;
			mem[8'h12] <= 16'h0028;
			mem[8'h14] <= 16'h0541;
			mem[8'h15] <= 16'h0600;
			mem[8'h18] <= 16'h2000;
			{n_wr, bc, nb, sda_pull, hold} <= '0;
		end else if (scl && ps && pd != sda) begin
			bc <= 4'h0;
			nb <= 3'h0;
			sda_pull <= 1'b0;
		end else if (scl && !ps && bc < 8) begin
			sh <= {sh[6:0], sda};
			bc <= bc + 4'h1;
		end else if (!ps || scl) begin
		end else begin
			// Slow answer stretches each low phase
			if (slow)
				hold <= 5'd20;
			if (bc == 8) begin
				bc <= 4'h9;
				nb <= nb + 3'h1;
				sda_pull <= nb != 0 || (sh[7:1] == DEV_ADDR && !sh[0]);
				if (nb == 1)
					ptr <= sh;
				if (nb == 2)
					hi <= sh;
				if (nb == 3) begin
					mem[ptr[6:0]] <= {hi, sh};
					n_wr <= n_wr + 6'h1;
				end
			end else if (bc == 9) begin
				bc <= 4'h0;
				sda_pull <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: oximetry_setup_asserts.sv
// Port checks for the setup sequencer
`timescale 1ns/1ps
`default_nettype none
module oximetry_setup_asserts (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [1:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_out,
	input wire logic        sda_oe
);
	default clocking dcb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic       prev_scl;
	logic [9:0] run;
	// ==========================================
	// Clock line level age
	always @(posedge sys_clk) begin
		prev_scl <= scl_oe;
		if (rst || scl_oe != prev_scl)
			run <= 10'h0;
		else if (run != 10'h3ff)
			run <= run + 10'h1;
	end
	// ==========================================
	// Assertions
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not low one cycle after request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	idle_wait_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	reset_idle_a: assert property ($fell(rst) |-> !scl_oe && !sda_oe && avs_waitrequest)
		else $error("lines not idle after reset");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address != 2'h1
		&& avs_address != 2'h2 |-> avs_readdata == 32'h0) else $error("nonzero read data");
	open_drain_a: assert property (!scl_out && !sda_out)
		else $error("line driven high");
	data_skew_a: assert property ($changed(scl_oe) |-> $stable(sda_oe))
		else $error("data moved with clock");
	quarter_min_a: assert property ($changed(scl_oe) |-> run >= 10'd249)
		else $error("clock phase shorter than a quarter");
	start_form_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:260] scl_oe)
		else $error("start not followed by clock low");
endmodule
bind oximetry_setup_sequencer oximetry_setup_asserts oximetry_setup_asserts_i (.sys_clk(sys_clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// File: oximetry_setup_defs.vh
// Constants for the oximetry setup sequencer
`ifndef OXIMETRY_SETUP_DEFS_VH
`define OXIMETRY_SETUP_DEFS_VH

// ==========================================
// Timing
`define CLK_PERIOD_NS         10
`define I2C_QUARTER_NS        2500
`define I2C_QUARTER_CYC       ((`I2C_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Last count of a quarter: 250 cycles, counted 0 to 249
`define I2C_QUARTER_LAST      8'hf9

// ==========================================
// Own register map, word index on avs_address
`define AVS_CTRL              2'h0
`define AVS_STATUS            2'h1
`define AVS_TARGET            2'h2
`define CTRL_GO_BIT           0
`define CTRL_CLEAR_BIT        1
`define STAT_BUSY_BIT         0
`define STAT_DONE_BIT         1
`define STAT_NACK_BIT         2
`define TARGET_RESET          7'h2a

// ==========================================
// Sequence length
`define SEQ_LAST              5'h1b

// ==========================================
// Device register offsets
`define REG_INT_PIN_CTL       8'h02
`define REG_OPERATING_MODE    8'h10
`define REG_SLOT_FIFO_EN      8'h11
`define REG_SAMPLE_RATE       8'h12
`define REG_DET_EMIT_ROUTE    8'h14
`define REG_SAMPLE_AVG        8'h15
`define REG_A_CH1_OFFSET      8'h18
`define REG_A_CH2_OFFSET      8'h19
`define REG_A_CH3_OFFSET      8'h1a
`define REG_A_CH4_OFFSET      8'h1b
`define REG_B_CH1_OFFSET      8'h1e
`define REG_B_CH2_OFFSET      8'h1f
`define REG_B_CH3_OFFSET      8'h20
`define REG_B_CH4_OFFSET      8'h21
`define REG_RED_COARSE        8'h23
`define REG_IR_COARSE         8'h24
`define REG_EMIT_FINE         8'h25
`define REG_A_PULSE_SHAPE     8'h30
`define REG_A_PULSE_TRAIN     8'h31
`define REG_B_PULSE_SHAPE     8'h35
`define REG_B_PULSE_TRAIN     8'h36
`define REG_A_FE_TIMING       8'h39
`define REG_B_FE_TIMING       8'h3b
`define REG_A_GAIN_FILTER     8'h42
`define REG_B_GAIN_FILTER     8'h44
`define REG_CONV_CLK_TIMING   8'h4e

// ==========================================
// Values written
`define VAL_MODE_PROGRAM      16'h0001
`define VAL_MODE_RUN          16'h0002
`define VAL_INT_PIN           16'h0001
`define VAL_SLOT_FIFO         16'h30a9
`define VAL_RATE_800HZ        16'h000a
`define VAL_ROUTE             16'h0116
`define VAL_AVG_8             16'h0330
`define VAL_OFFSET_UNUSED     16'h3fff
`define VAL_OFFSET_HALF       16'h1ff0
`define VAL_RED_COARSE        16'h3005
`define VAL_IR_COARSE         16'h3007
`define VAL_EMIT_FINE         16'h0207
`define VAL_PULSE_SHAPE       16'h0319
`define VAL_PULSE_TRAIN       16'h0813
`define VAL_FE_TIMING         16'h21f3
`define VAL_GAIN_FILTER       16'h1c36
`define VAL_CONV_CLK          16'h0040

`endif

// File: oximetry_setup_sequencer.v
// Host sequencer writing the oximetry setup over I2C
// ==========================================
// Overview of operation
// - Program mode written before any other
// - Run mode written after all configuration
// - Interrupt pin enabled, active low
// - Slots sample, drop when full, 32-bit
// - Sample rate set to 800 Hz
// - All photodiodes to channels 3, 4
// - Eight samples averaged per slot
// - Red 100 mA, infrared 130 mA
// - Fine emitter timing 593.75 ns both
// - Pulse offset 25 us, width 3 us
// - Eight pulses every 19 us
// - Front-end fine, coarse offset and window
// - Gain, filter, reference and integrator set
// - Converter clock runs only during conversion
`include "oximetry_setup_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module oximetry_setup_sequencer (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire [1:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire        scl_in,
	output reg         scl_out,
	output reg         scl_oe,
	input  wire        sda_in,
	output reg         sda_out,
	output reg         sda_oe
);

	// ==========================================
	// States and constants
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_START = 4'h2;
	localparam [3:0] ST_BYTE  = 4'h4;
	localparam [3:0] ST_STOP  = 4'h8;
	localparam [7:0] QLAST    = `I2C_QUARTER_LAST;

	reg  [3:0]  state;
	reg  [1:0]  phase;
	reg  [7:0]  qcnt;
	reg  [4:0]  step;
	reg  [1:0]  byte_idx;
	reg  [3:0]  bit_idx;
	reg  [7:0]  shift;
	reg         ack_bit;
	reg         err_pending;
	reg         done;
	reg         nack;
	reg  [6:0]  target;
	reg         next_scl_oe;
	reg         next_sda_oe;
	wire        busy;
	wire        stretch;
	wire        tick;
	wire        wr_commit;
	wire        go_req;
	wire        clr_req;
	wire        bus_req;
	wire        target_wr;
	wire [31:0] status_word;

	// ==========================================
	// Setup table
	// untouched registers left alone
	// fixed order, one entry per write
	function [23:0] setup_entry;
		input [4:0] idx;
		begin
			case (idx)
				5'h00: setup_entry = {`REG_OPERATING_MODE, `VAL_MODE_PROGRAM};
				5'h01: setup_entry = {`REG_INT_PIN_CTL, `VAL_INT_PIN};
				5'h02: setup_entry = {`REG_SLOT_FIFO_EN, `VAL_SLOT_FIFO};
				5'h03: setup_entry = {`REG_SAMPLE_RATE, `VAL_RATE_800HZ};
				5'h04: setup_entry = {`REG_DET_EMIT_ROUTE, `VAL_ROUTE};
				5'h05: setup_entry = {`REG_SAMPLE_AVG, `VAL_AVG_8};
				5'h06: setup_entry = {`REG_A_CH1_OFFSET, `VAL_OFFSET_UNUSED};
				5'h07: setup_entry = {`REG_A_CH2_OFFSET, `VAL_OFFSET_UNUSED};
				5'h08: setup_entry = {`REG_A_CH3_OFFSET, `VAL_OFFSET_HALF};
				5'h09: setup_entry = {`REG_A_CH4_OFFSET, `VAL_OFFSET_HALF};
				5'h0a: setup_entry = {`REG_B_CH1_OFFSET, `VAL_OFFSET_UNUSED};
				5'h0b: setup_entry = {`REG_B_CH2_OFFSET, `VAL_OFFSET_UNUSED};
				5'h0c: setup_entry = {`REG_B_CH3_OFFSET, `VAL_OFFSET_HALF};
				5'h0d: setup_entry = {`REG_B_CH4_OFFSET, `VAL_OFFSET_HALF};
				5'h0e: setup_entry = {`REG_RED_COARSE, `VAL_RED_COARSE};
				5'h0f: setup_entry = {`REG_IR_COARSE, `VAL_IR_COARSE};
				5'h10: setup_entry = {`REG_EMIT_FINE, `VAL_EMIT_FINE};
				5'h11: setup_entry = {`REG_A_PULSE_SHAPE, `VAL_PULSE_SHAPE};
				5'h12: setup_entry = {`REG_A_PULSE_TRAIN, `VAL_PULSE_TRAIN};
				5'h13: setup_entry = {`REG_B_PULSE_SHAPE, `VAL_PULSE_SHAPE};
				5'h14: setup_entry = {`REG_B_PULSE_TRAIN, `VAL_PULSE_TRAIN};
				5'h15: setup_entry = {`REG_A_FE_TIMING, `VAL_FE_TIMING};
				5'h16: setup_entry = {`REG_B_FE_TIMING, `VAL_FE_TIMING};
				5'h17: setup_entry = {`REG_A_GAIN_FILTER, `VAL_GAIN_FILTER};
				5'h18: setup_entry = {`REG_B_GAIN_FILTER, `VAL_GAIN_FILTER};
				5'h19: setup_entry = {`REG_CONV_CLK_TIMING, `VAL_CONV_CLK};
				5'h1a: setup_entry = {`REG_OPERATING_MODE, `VAL_MODE_RUN};
				default: setup_entry = {`REG_OPERATING_MODE, `VAL_MODE_RUN};
			endcase
		end
	endfunction

	// Byte order on the wire: address, register, data high, data low
	function [7:0] frame_byte;
		input [1:0] which;
		input [4:0] idx;
		input [6:0] dev;
		reg   [23:0] e;
		begin
			e = setup_entry(idx);
			case (which)
				2'h0:    frame_byte = {dev, 1'b0};
				2'h1:    frame_byte = e[23:16];
				2'h2:    frame_byte = e[15:8];
				default: frame_byte = e[7:0];
			endcase
		end
	endfunction

	// ==========================================
	// Avalon slave
	// One wait state: answer registered, read data stands at release
	assign wr_commit = avs_write & ~avs_waitrequest;
	assign go_req    = wr_commit & (avs_address == `AVS_CTRL) & avs_byteenable[0]
	                   & avs_writedata[`CTRL_GO_BIT];
	assign clr_req   = wr_commit & (avs_address == `AVS_CTRL) & avs_byteenable[0]
	                   & avs_writedata[`CTRL_CLEAR_BIT];
	assign busy      = (state != ST_IDLE);

	// ==========================================
	// Status and target words
	// Lane 0 carries flags and target, lane 1 the status step; writes use lane 0 only
	assign bus_req     = (avs_read | avs_write) & avs_waitrequest;
	assign target_wr   = wr_commit & (avs_address == `AVS_TARGET) & avs_byteenable[0] & ~busy;
	assign status_word = {19'h00000, step, 5'h00, nack, done, busy};

	always @(posedge sys_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (bus_req) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= 32'h00000000;
			if (avs_read) begin
				case (avs_address)
					`AVS_STATUS: avs_readdata <= status_word;
					`AVS_TARGET: avs_readdata <= {25'h0000000, target};
					default:     avs_readdata <= 32'h00000000;
				endcase
			end
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			target <= `TARGET_RESET;
		end else if (target_wr) begin
			// Address frozen while a sequence runs
			target <= avs_writedata[6:0];
		end
	end

	// ==========================================
	// Line drive
	// Open drain: only ever pulls low, so outputs stay 0
	always @* begin
		next_scl_oe = 1'b0;
		next_sda_oe = 1'b0;
		case (state)
			ST_START: begin
				next_scl_oe = phase[1];
				next_sda_oe = (phase != 2'h0);
			end
			ST_BYTE: begin
				next_scl_oe = (phase == 2'h0) | (phase == 2'h3);
				next_sda_oe = (bit_idx != 4'h8) & ~shift[7];
			end
			ST_STOP: begin
				next_scl_oe = (phase == 2'h0);
				next_sda_oe = ~phase[1];
			end
			default: begin
				next_scl_oe = 1'b0;
				next_sda_oe = 1'b0;
			end
		endcase
	end

	// Clock held low by the device pauses the quarter timer
	assign stretch = ~scl_oe & ~scl_in;
	assign tick    = ~stretch & (qcnt == QLAST);

	always @(posedge sys_clk) begin
		if (rst) begin
			scl_out <= 1'b0;
			scl_oe  <= 1'b0;
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			scl_oe  <= next_scl_oe;
			sda_out <= 1'b0;
			sda_oe  <= next_sda_oe;
		end
	end

	// ==========================================
	// Quarter timer
	// Stalls while the device stretches the clock
	always @(posedge sys_clk) begin
		if (rst) begin
			phase <= 2'h0;
			qcnt  <= 8'h00;
		end else if (state == ST_IDLE) begin
			phase <= 2'h0;
			qcnt  <= 8'h00;
		end else if (!stretch) begin
			if (tick) begin
				phase <= phase + 2'h1;
				qcnt  <= 8'h00;
			end else begin
				qcnt <= qcnt + 8'h01;
			end
		end
	end

	// ==========================================
	// Sequencer
	always @(posedge sys_clk) begin
		if (rst) begin
			state       <= ST_IDLE;
			step        <= 5'h00;
			byte_idx    <= 2'h0;
			bit_idx     <= 4'h0;
			shift       <= 8'h00;
			ack_bit     <= 1'b0;
			err_pending <= 1'b0;
			done        <= 1'b0;
			nack        <= 1'b0;
		end else begin
			// Later sets below win over this clear
			if (clr_req) begin
				done <= 1'b0;
				nack <= 1'b0;
			end
			case (state)
				ST_IDLE: begin
					// GO counts only while idle
					if (go_req) begin
						step        <= 5'h00;
						err_pending <= 1'b0;
						done        <= 1'b0;
						nack        <= 1'b0;
						state       <= ST_START;
					end
				end
				ST_START: begin
					if (tick && phase == 2'h3) begin
						byte_idx <= 2'h0;
						bit_idx  <= 4'h0;
						shift    <= frame_byte(2'h0, step, target);
						state    <= ST_BYTE;
					end
				end
				ST_BYTE: begin
					// Acknowledge taken late in the high phase
					if (tick && phase == 2'h2) begin
						ack_bit <= sda_in;
					end
					if (tick && phase == 2'h3) begin
						if (bit_idx != 4'h8) begin
							bit_idx <= bit_idx + 4'h1;
							shift   <= {shift[6:0], 1'b1};
						end else if (ack_bit) begin
							// Abandon the sequence on a refused byte
							err_pending <= 1'b1;
							state       <= ST_STOP;
						end else if (byte_idx == 2'h3) begin
							state <= ST_STOP;
						end else begin
							byte_idx <= byte_idx + 2'h1;
							bit_idx  <= 4'h0;
							shift    <= frame_byte(byte_idx + 2'h1, step, target);
						end
					end
				end
				ST_STOP: begin
					if (tick && phase == 2'h3) begin
						if (err_pending) begin
							nack  <= 1'b1;
							state <= ST_IDLE;
						end else if (step == `SEQ_LAST) begin
							done  <= 1'b1;
							state <= ST_IDLE;
						end else begin
							step  <= step + 5'h01;
							state <= ST_START;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the setup sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        slow = 1'b0;
	logic [1:0]  avs_address = 2'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] q;
	int          num_errors = 0;
	int          n_compared = 0;
	wire  logic [31:0] avs_readdata;
	wire  logic  avs_waitrequest, scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull;
	// Pull-ups on both open-drain lines
	wire  logic  scl = !(scl_oe || scl_pull);
	wire  logic  sda = !(sda_oe || sda_pull);
	always #5 sys_clk = ~sys_clk;
	oximetry_setup_sequencer oximetry_setup_sequencer_i (.sys_clk(sys_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
	oximetry_device_model dev_i (.sys_clk(sys_clk), .rst(rst), .slow(slow), .scl(scl), .sda(sda),
		.scl_pull(scl_pull), .sda_pull(sda_pull));
	task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		`CHK("bus answer", 1'b0, avs_waitrequest)
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Device write count is the far side's progress
	task automatic wait_wr(input int k);
		int n = 0;
		while (dev_i.n_wr < k && n < 50000) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	task t_regs;
		bus(2'h1, 1'b0, 0); `CHK("status", 32'h0, q)
		bus(2'h2, 1'b0, 0); `CHK("target", 32'h2a, q)
		bus(2'h2, 1'b1, 32'h15); bus(2'h2, 1'b0, 0); `CHK("target rw", 32'h15, q)
		bus(2'h3, 1'b1, 32'h7); bus(2'h3, 1'b0, 0); `CHK("unmapped", 32'h0, q)
		bus(2'h0, 1'b0, 0); `CHK("ctrl", 32'h0, q)
		bus(2'h2, 1'b1, 32'h2a);
	endtask
	task t_seq;
		slow <= 1'b1;
		bus(2'h0, 1'b1, 32'h1);
		bus(2'h1, 1'b0, 0); `CHK("busy", 1'b1, q[0])
		bus(2'h2, 1'b1, 32'h15); bus(2'h2, 1'b0, 0); `CHK("target locked", 32'h2a, q)
		wait_wr(1);
		`CHK("mode first", 16'h0001, dev_i.mem[8'h10])
		`CHK("pin later", 16'h0000, dev_i.mem[8'h02])
		wait_wr(2);
		`CHK("pin ctl", 16'h0001, dev_i.mem[8'h02])
		`CHK("rate default", 16'h0028, dev_i.mem[8'h12])
		rst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		bus(2'h1, 1'b0, 0); `CHK("reset status", 32'h0, q)
	endtask
	task t_nack;
		int n = 0;
		slow <= 1'b0;
		bus(2'h2, 1'b1, 32'h15); bus(2'h0, 1'b1, 32'h1);
		do begin
			bus(2'h1, 1'b0, 0);
			n++;
		end while (q[0] !== 1'b0 && n < 10000);
		`CHK("nack status", 3'b100, q[2:0])
		`CHK("no write", 6'h0, dev_i.n_wr)
		bus(2'h0, 1'b1, 32'h2); bus(2'h1, 1'b0, 0); `CHK("cleared", 3'b000, q[2:0])
	endtask
	task tally_and_finish;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#990_000;
		num_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs;
		t_seq;
		t_nack;
		tally_and_finish;
	end
endmodule
`default_nettype wire
